/* src/swb_pkg.sv */
/*
  Shared constants, types and timing figures for the single-wire bus command unit.
  Assumes a 125 MHz system clock; all times are held in ns and turned into cycles here or in the swb_cmd_unit parameters.
*/
package swb_pkg;

  localparam int CLK_MHZ = 125;

  function automatic int cyc_up(input int t_ns);
    int c;
    c = (t_ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // Bus slot and reset figures in ns
  localparam int SLOT_REG_NS     = 65000;
  localparam int W0_LOW_REG_NS   = 60000;
  localparam int W1_LOW_REG_NS   = 8000;
  localparam int W1_LOW_FLEX_NS  = 12000;
  localparam int SAMP_REG_NS     = 15000;
  localparam int SAMP_FLEX_NS    = 22000;
  localparam int SLOT_HS_NS      = 10000;
  localparam int W0_LOW_HS_NS    = 7500;
  localparam int W1_LOW_HS_NS    = 1000;
  localparam int SAMP_HS_NS      = 2000;
  localparam int RST_LOW_REG_NS  = 512000;
  localparam int RST_SAMP_REG_NS = 584000;
  localparam int RST_END_REG_NS  = 1024000;
  localparam int RST_LOW_HS_NS   = 64000;
  localparam int RST_SAMP_HS_NS  = 72000;
  localparam int RST_END_HS_NS   = 128000;

  // Counts at or below 4096 cycles
  localparam int W1_LOW_REG_CYC  = cyc_up(W1_LOW_REG_NS);
  localparam int W1_LOW_FLEX_CYC = cyc_up(W1_LOW_FLEX_NS);
  localparam int SAMP_REG_CYC    = cyc_up(SAMP_REG_NS);
  localparam int SAMP_FLEX_CYC   = cyc_up(SAMP_FLEX_NS);
  localparam int SLOT_HS_CYC     = cyc_up(SLOT_HS_NS);
  localparam int W0_LOW_HS_CYC   = cyc_up(W0_LOW_HS_NS);
  localparam int W1_LOW_HS_CYC   = cyc_up(W1_LOW_HS_NS);
  localparam int SAMP_HS_CYC     = cyc_up(SAMP_HS_NS);

  localparam int TMR_W = 24;

  // Host byte codes
  localparam logic [7:0] CODE_DATA_MODE = 8'hE1;
  localparam logic [7:0] CODE_CMD_MODE  = 8'hE3;
  localparam logic [7:0] CODE_PULSE_END = 8'hF1;
  localparam logic [7:0] RESP_SB_HI     = 8'hEF;
  localparam logic [7:0] RESP_SB_LO     = 8'hEC;
  localparam logic [7:0] RESP_ARM_HI    = 8'hF6;
  localparam logic [7:0] RESP_ARM_LO    = 8'h76;
  localparam logic [7:0] RESP_RST_BASE  = 8'hCC;

  // Command field positions and function codes
  localparam int CMD_VAL = 4;
  localparam int CMD_OPT = 1;
  localparam logic [1:0] FN_SB    = 2'h0;
  localparam logic [1:0] FN_SAC   = 2'h1;
  localparam logic [1:0] FN_RST   = 2'h2;
  localparam logic [1:0] FN_PULSE = 2'h3;
  localparam logic [1:0] SPD_REG  = 2'h0;
  localparam logic [1:0] SPD_FLEX = 2'h1;
  localparam logic [1:0] SPD_HS   = 2'h2;
  localparam logic [1:0] PRES_SHORT = 2'h0;
  localparam logic [1:0] PRES_SEEN  = 2'h1;
  localparam logic [1:0] PRES_NONE  = 2'h3;

  // Register map and reset values
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_SPU_LEN  = 8'h04;
  localparam logic [7:0]  OFS_PROG_LEN = 8'h08;
  localparam logic [7:0]  OFS_STATUS   = 8'h0C;
  localparam logic [0:0]  CTRL_RST     = 1'h1;
  localparam logic [23:0] SPU_LEN_RST  = 24'h00_F424;
  localparam logic [23:0] PROG_LEN_RST = 24'h00_0FA0;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_SPD_LSB  = 3;
  localparam int ST_ARMED    = 5;
  localparam int ST_ACCEL    = 6;
  localparam int ST_ACC_ERR  = 7;
  localparam int ST_BUSY     = 8;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_SLOT  = 6'h02,
    ST_RSTP  = 6'h04,
    ST_SEND  = 6'h08,
    ST_PULSE = 6'h10,
    ST_SEND2 = 6'h20
  } swb_state_t;

  typedef enum logic [4:0] {
    JOB_SB    = 5'h01,
    JOB_DATA  = 5'h02,
    JOB_ACC   = 5'h04,
    JOB_RST   = 5'h08,
    JOB_PULSE = 5'h10
  } swb_job_t;

  typedef enum logic [2:0] {
    MODE_CMD   = 3'h1,
    MODE_DATA  = 3'h2,
    MODE_CHECK = 3'h4
  } swb_mode_t;

  typedef struct packed {
    logic bus_o;
    logic bus_oe;
    logic spu_en;
    logic prog_en;
  } swb_drv_t;

  typedef struct packed {
    logic [TMR_W-1:0] low;
    logic [TMR_W-1:0] samp;
    logic [TMR_W-1:0] fin;
  } swb_tm_t;

endpackage

/* src/swb_cmd_unit.sv */
/*
  Command interpreter for a single-wire open-drain bus: host byte stream in, response
  bytes out, bus slots, reset pulses, strong pullup and programming pulse, search accelerator.
  Assumes an external UART that frames bytes, an AHB-Lite master and an external pin pad.
*/
// Function
// - Single Bit drives one slot at latched speed, bit 4 picks write value
// - Read slot uses the write-1 waveform and samples the bus
// - Single Bit reply echoes bits 7:2, both low bits carry sampled value
// - Single Bit bit 1 requests a strong pullup right after the slot
// - After that pullup a second reply EFh or ECh follows
// - Speed 00 and 11 regular, 01 flexible, 10 high speed
// - Accelerator command loads bit 4 into flag; data bytes become 12 slots
// - Accelerator command gives no reply and no bus activity
// - Accelerator command speed field takes effect at once
// - Pulse bit 4 selects 5V pullup or 12V programming pulse
// - Pulse bit 1 arms or disarms per-byte pullup in all combinations
// - In command mode F1h ends a running pulse early
// - Pulse reply only after end by timeout, load sensor or host
// - Pulse reply echoes bits 7:2, low bits undefined
// - Armed data byte pullup end reports F6h or 76h by MSB
// - Reset reply 11, reserved, 011, then presence code
// - Accelerated search: one reply byte per host byte, 16 per pass
// - Accelerator returns chosen path and conflict flag per bit
// - Per bit two read slots, a decision, one write slot
// - Bytes are 8 data bits, framing left to the UART
// - E1h and E3h switch modes and give no reply
// - Speed bits of Single Bit, accelerator and reset commands latch and apply immediately
module swb_cmd_unit
  import swb_pkg::*;
#(
  parameter int SLOT_REG_CYC     = swb_pkg::cyc_up(swb_pkg::SLOT_REG_NS),
  parameter int W0_LOW_REG_CYC   = swb_pkg::cyc_up(swb_pkg::W0_LOW_REG_NS),
  parameter int RST_LOW_REG_CYC  = swb_pkg::cyc_up(swb_pkg::RST_LOW_REG_NS),
  parameter int RST_SAMP_REG_CYC = swb_pkg::cyc_up(swb_pkg::RST_SAMP_REG_NS),
  parameter int RST_END_REG_CYC  = swb_pkg::cyc_up(swb_pkg::RST_END_REG_NS),
  parameter int RST_LOW_HS_CYC   = swb_pkg::cyc_up(swb_pkg::RST_LOW_HS_NS),
  parameter int RST_SAMP_HS_CYC  = swb_pkg::cyc_up(swb_pkg::RST_SAMP_HS_NS),
  parameter int RST_END_HS_CYC   = swb_pkg::cyc_up(swb_pkg::RST_END_HS_NS)
)(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Host byte stream in
  input  wire logic [7:0]       rx_data,
  input  wire logic             rx_valid,
  output logic                  rx_ready,
  // Response byte stream out
  output logic [7:0]            tx_data,
  output logic                  tx_valid,
  input  wire logic             tx_ready,
  // Bus pin and drivers
  input  wire logic             bus_i,
  input  wire logic             demand_low,
  output swb_pkg::swb_drv_t     drv,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata
);
  import swb_pkg::*;

  if (W0_LOW_REG_CYC >= SLOT_REG_CYC || SAMP_FLEX_CYC >= SLOT_REG_CYC ||
      RST_LOW_REG_CYC >= RST_SAMP_REG_CYC || RST_SAMP_REG_CYC >= RST_END_REG_CYC ||
      RST_LOW_HS_CYC >= RST_SAMP_HS_CYC || RST_SAMP_HS_CYC >= RST_END_HS_CYC ||
      RST_END_REG_CYC >= (1 << TMR_W))
  begin : g_bad_timing
    $error("swb_cmd_unit: inconsistent timing parameters");
  end

  swb_state_t        state;
  swb_job_t          job;
  swb_mode_t         mode;
  swb_tm_t           tm;
  logic [TMR_W-1:0]  tmr;
  logic [7:0]        cmd;
  logic [7:0]        dbyte;
  logic [7:0]        rbyte;
  logic [2:0]        bit_cnt;
  logic [1:0]        pos;
  logic [1:0]        phase;
  logic [1:0]        speed;
  logic              armed;
  logic              accel;
  logic              acc_err;
  logic              acc_b0;
  logic              acc_b1;
  logic              smp;
  logic              pulse_prog;
  logic              ctrl_dyn;
  logic [23:0]       spu_len;
  logic [23:0]       prog_len;
  logic              slot_val;
  logic              slot_end;
  logic              rx_take;
  logic              idle_take;
  logic              as_data;
  logic              as_cmd;
  logic              comm_ok;
  logic              do_sb;
  logic              do_sac;
  logic              do_rst;
  logic              do_pulse;
  logic              f1_take;
  logic              pulse_end;
  logic [23:0]       pulse_len;
  logic              acc_none;
  logic              acc_conf;
  logic              acc_b2;
  logic              acc_rn;
  logic              pulse_after;
  logic              dp_wr;
  logic              rd_pend;
  logic [7:0]        dp_addr;
  logic [31:0]       rd_mux;

  // Host byte decode
  assign rx_take   = rx_valid && rx_ready;
  assign idle_take = rx_take && (state == ST_IDLE);
  assign as_data   = idle_take && ((mode == MODE_DATA && rx_data != CODE_CMD_MODE) ||
                                   (mode == MODE_CHECK && rx_data == CODE_CMD_MODE));
  assign as_cmd    = idle_take && (mode == MODE_CMD ||
                                   (mode == MODE_CHECK && rx_data != CODE_CMD_MODE));
  assign comm_ok   = as_cmd && rx_data[7] && rx_data[0] && rx_data != CODE_DATA_MODE &&
                     rx_data != CODE_CMD_MODE && rx_data != CODE_PULSE_END;
  assign do_sb     = comm_ok && rx_data[6:5] == FN_SB;
  assign do_sac    = comm_ok && rx_data[6:5] == FN_SAC && !rx_data[CMD_OPT];
  assign do_rst    = comm_ok && rx_data[6:5] == FN_RST && !rx_data[CMD_OPT];
  assign do_pulse  = comm_ok && rx_data[6:5] == FN_PULSE && rx_data[3:2] == 2'h3;

  // Only F1h is taken while a pulse runs, and only in command mode
  assign rx_ready = ((state == ST_IDLE) && !tx_valid) ||
                    ((state == ST_PULSE) && mode == MODE_CMD &&
                     rx_data == CODE_PULSE_END);
  assign f1_take  = rx_take && (state == ST_PULSE);

  // Search decision for the current bit position
  assign acc_rn   = dbyte[{pos, 1'b1}];
  assign acc_none = acc_b0 && acc_b1;
  assign acc_conf = !acc_b0 && !acc_b1;
  assign acc_b2   = acc_none ? 1'b1 : (acc_conf ? acc_rn : acc_b0);

  always_comb
  begin
    case (job)
      JOB_SB:   slot_val = cmd[CMD_VAL];
      JOB_DATA: slot_val = dbyte[bit_cnt];
      JOB_ACC:  slot_val = (phase == 2'h2) ? acc_b2 : 1'b1;
      default:  slot_val = 1'b1;
    endcase
  end

  // Waveform figures by speed; 11 falls back to regular
  always_comb
  begin
    tm = '0;
    if (state == ST_RSTP)
    begin
      if (speed == SPD_HS)
      begin
        tm.low  = TMR_W'(RST_LOW_HS_CYC);
        tm.samp = TMR_W'(RST_SAMP_HS_CYC);
        tm.fin  = TMR_W'(RST_END_HS_CYC - 1);
      end
      else
      begin
        tm.low  = TMR_W'(RST_LOW_REG_CYC);
        tm.samp = TMR_W'(RST_SAMP_REG_CYC);
        tm.fin  = TMR_W'(RST_END_REG_CYC - 1);
      end
    end
    else if (speed == SPD_HS)
    begin
      tm.low  = slot_val ? TMR_W'(W1_LOW_HS_CYC) : TMR_W'(W0_LOW_HS_CYC);
      tm.samp = TMR_W'(SAMP_HS_CYC);
      tm.fin  = TMR_W'(SLOT_HS_CYC - 1);
    end
    else if (speed == SPD_FLEX)
    begin
      tm.low  = slot_val ? TMR_W'(W1_LOW_FLEX_CYC) : TMR_W'(W0_LOW_REG_CYC);
      tm.samp = TMR_W'(SAMP_FLEX_CYC);
      tm.fin  = TMR_W'(SLOT_REG_CYC - 1);
    end
    else
    begin
      tm.low  = slot_val ? TMR_W'(W1_LOW_REG_CYC) : TMR_W'(W0_LOW_REG_CYC);
      tm.samp = TMR_W'(SAMP_REG_CYC);
      tm.fin  = TMR_W'(SLOT_REG_CYC - 1);
    end
  end

  assign slot_end  = (state == ST_SLOT || state == ST_RSTP) && tmr == tm.fin;
  assign pulse_len = pulse_prog ? prog_len : spu_len;
  // Zero length means unlimited; not for use with per-byte pullup
  assign pulse_end = (state == ST_PULSE) &&
                     ((pulse_len != 24'h00_0000 && tmr >= pulse_len - 24'h00_0001) ||
                      (!pulse_prog && ctrl_dyn && demand_low) || f1_take);
  // Accelerated bytes never get the per-byte pullup
  assign pulse_after = (job == JOB_SB && cmd[CMD_OPT]) ||
                       (job == JOB_DATA && armed);

  // Sequencer
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state      <= ST_IDLE;
      job        <= JOB_SB;
      tmr        <= '0;
      cmd        <= 8'h00;
      dbyte      <= 8'h00;
      bit_cnt    <= 3'h0;
      pos        <= 2'h0;
      phase      <= 2'h0;
      pulse_prog <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          tmr     <= '0;
          bit_cnt <= 3'h0;
          pos     <= 2'h0;
          phase   <= 2'h0;
          if (as_data)
          begin
            dbyte <= rx_data;
            job   <= accel ? JOB_ACC : JOB_DATA;
            state <= ST_SLOT;
          end
          else if (do_sb)
          begin
            cmd   <= rx_data;
            job   <= JOB_SB;
            state <= ST_SLOT;
          end
          else if (do_rst)
          begin
            cmd   <= rx_data;
            job   <= JOB_RST;
            state <= ST_RSTP;
          end
          else if (do_pulse)
          begin
            cmd        <= rx_data;
            job        <= JOB_PULSE;
            pulse_prog <= rx_data[CMD_VAL];
            state      <= ST_PULSE;
          end
        end
        ST_SLOT, ST_RSTP:
        begin
          if (slot_end)
          begin
            tmr <= '0;
            if (job == JOB_DATA && bit_cnt != 3'h7)
              bit_cnt <= bit_cnt + 3'h1;
            else if (job == JOB_ACC && phase != 2'h2)
              phase <= phase + 2'h1;
            else if (job == JOB_ACC && pos != 2'h3)
            begin
              phase <= 2'h0;
              pos   <= pos + 2'h1;
            end
            else
              state <= ST_SEND;
          end
          else
            tmr <= tmr + 1'b1;
        end
        ST_SEND:
        begin
          tmr <= '0;
          if (!tx_valid)
          begin
            pulse_prog <= 1'b0;
            state      <= pulse_after ? ST_PULSE : ST_IDLE;
          end
        end
        ST_PULSE:
        begin
          if (pulse_end)
            state <= ST_SEND2;
          else
            tmr <= tmr + 1'b1;
        end
        ST_SEND2:
        begin
          if (!tx_valid)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Mode tracking; mode codes themselves draw no reply
  always_ff @(posedge clk)
  begin
    if (reset)
      mode <= MODE_CMD;
    else if (as_cmd)
      mode <= (rx_data == CODE_DATA_MODE) ? MODE_DATA : MODE_CMD;
    else if (idle_take && mode == MODE_DATA && rx_data == CODE_CMD_MODE)
      mode <= MODE_CHECK;
    else if (idle_take && mode == MODE_CHECK)
      mode <= MODE_DATA;
  end

  // Speed, arm and accelerator state
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      speed   <= SPD_REG;
      armed   <= 1'b0;
      accel   <= 1'b0;
      acc_err <= 1'b0;
    end
    else
    begin
      if (do_sb || do_sac || do_rst)
        speed <= rx_data[3:2];
      if (do_sac)
        accel <= rx_data[CMD_VAL];
      if (do_pulse)
        armed <= rx_data[CMD_OPT];
      // Error sticks until the accelerator is switched off
      if (slot_end && job == JOB_ACC && phase == 2'h2 && acc_none)
        acc_err <= 1'b1;
      else if (do_sac && !rx_data[CMD_VAL])
        acc_err <= 1'b0;
    end
  end

  // Bus sampling
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      smp    <= 1'b1;
      acc_b0 <= 1'b1;
      acc_b1 <= 1'b1;
    end
    else
    begin
      if ((state == ST_SLOT || state == ST_RSTP) && tmr == tm.samp)
        smp <= bus_i;
      if (slot_end && job == JOB_ACC && phase == 2'h0)
        acc_b0 <= smp;
      if (slot_end && job == JOB_ACC && phase == 2'h1)
        acc_b1 <= smp;
    end
  end

  // Response byte assembly
  always_ff @(posedge clk)
  begin
    if (reset)
      rbyte <= 8'h00;
    else if (slot_end)
    begin
      case (job)
        JOB_SB:
          rbyte <= {cmd[7:2], smp, smp};
        JOB_DATA:
          rbyte <= {smp, rbyte[7:1]};
        JOB_ACC:
          if (phase == 2'h2)
          begin
            rbyte[{pos, 1'b0}] <= acc_none || acc_conf;
            rbyte[{pos, 1'b1}] <= acc_err || acc_b2;
          end
        JOB_RST:
          if (!bus_i)
            rbyte <= RESP_RST_BASE | {6'h00, PRES_SHORT};
          else
            rbyte <= RESP_RST_BASE | {6'h00, smp ? PRES_NONE : PRES_SEEN};
        default:
          rbyte <= rbyte;
      endcase
    end
    else if (pulse_end)
    begin
      case (job)
        JOB_PULSE: rbyte <= {cmd[7:2], 2'h0};
        JOB_SB:    rbyte <= smp ? RESP_SB_HI : RESP_SB_LO;
        default:   rbyte <= rbyte[7] ? RESP_ARM_HI : RESP_ARM_LO;
      endcase
    end
  end

  // Response output; one byte per host data byte, two for an armed data byte with its pullup, keeps the host from overrunning
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
    end
    else if ((state == ST_SEND || state == ST_SEND2) && !tx_valid)
    begin
      tx_valid <= 1'b1;
      tx_data  <= rbyte;
    end
    else if (tx_ready)
      tx_valid <= 1'b0;
  end

  // Pin drivers, registered
  always_ff @(posedge clk)
  begin
    if (reset)
      drv <= '0;
    else
    begin
      drv.bus_o   <= 1'b0;
      drv.bus_oe  <= (state == ST_SLOT || state == ST_RSTP) && tmr < tm.low;
      drv.spu_en  <= (state == ST_PULSE) && !pulse_end && !pulse_prog;
      drv.prog_en <= (state == ST_PULSE) && !pulse_end && pulse_prog;
    end
  end

  // AHB-Lite slave: writes zero wait, reads one wait state
  assign hreadyout = !rd_pend;
  assign hresp     = 1'b0;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (dp_addr)
      OFS_CTRL:     rd_mux = {31'h0000_0000, ctrl_dyn};
      OFS_SPU_LEN:  rd_mux = {8'h00, spu_len};
      OFS_PROG_LEN: rd_mux = {8'h00, prog_len};
      OFS_STATUS:
      begin
        rd_mux[ST_MODE_LSB +: 3] = mode;
        rd_mux[ST_SPD_LSB +: 2]  = speed;
        rd_mux[ST_ARMED]         = armed;
        rd_mux[ST_ACCEL]         = accel;
        rd_mux[ST_ACC_ERR]       = acc_err;
        rd_mux[ST_BUSY]          = state != ST_IDLE;
      end
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dp_wr   <= 1'b0;
      rd_pend <= 1'b0;
      dp_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end
    else
    begin
      dp_wr   <= hsel && hready && htrans[1] && hwrite;
      rd_pend <= hsel && hready && htrans[1] && !hwrite;
      if (hsel && hready && htrans[1])
        dp_addr <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
      if (rd_pend)
        hrdata <= rd_mux;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrl_dyn <= CTRL_RST;
      spu_len  <= SPU_LEN_RST;
      prog_len <= PROG_LEN_RST;
    end
    else if (dp_wr)
    begin
      case (dp_addr)
        OFS_CTRL:     ctrl_dyn <= hwdata[0];
        OFS_SPU_LEN:  spu_len  <= hwdata[23:0];
        OFS_PROG_LEN: prog_len <= hwdata[23:0];
        default:      ctrl_dyn <= ctrl_dyn;
      endcase
    end
  end

endmodule

/* tb/swb_cmd_props.sv */
/*
  Checker on the ports of swb_cmd_unit.
  Assumes one clock and the synchronous reset, attached by bind.
*/
module swb_cmd_props
  import swb_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset,
  // Host streams
  input wire logic [7:0]        rx_data,
  input wire logic              rx_valid,
  input wire logic              rx_ready,
  input wire logic [7:0]        tx_data,
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  // Bus drivers and register bus
  input wire swb_pkg::swb_drv_t drv,
  input wire logic              hsel,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp
);
  import swb_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_pulse_off;
    ##[1:8] !(drv.spu_en || drv.prog_en);
  endsequence
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("response byte changed before taken");
  a_rd_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> s_rd_wait)
    else $error("read wait state wrong");
  a_wr_nowait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
  a_bus_open: assert property (drv.bus_o == 1'b0)
    else $error("bus driven high");
  a_one_pulse: assert property (!(drv.spu_en && drv.prog_en))
    else $error("both pulse kinds on");
  a_pulse_float: assert property (drv.spu_en || drv.prog_en |-> !drv.bus_oe)
    else $error("bus pulled low during pulse");
  a_mode_quiet: assert property (rx_valid && rx_ready && rx_data[7:2] == 6'h38
    && rx_data[0] |=> !tx_valid [*4])
    else $error("mode code answered");
  a_f1_only: assert property ((drv.spu_en || drv.prog_en) && rx_ready
    |-> rx_data == CODE_PULSE_END)
    else $error("byte taken during pulse");
  a_f1_stops: assert property (rx_valid && rx_ready && rx_data == CODE_PULSE_END
    && drv.prog_en |-> s_pulse_off)
    else $error("pulse not ended");
endmodule
bind swb_cmd_unit swb_cmd_props u_swb_cmd_props (.clk(clk), .reset(reset),
  .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .drv(drv), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp));

/* tb/swb_host_model.sv */
/*
  Host model: sends whole bytes and takes response bytes.
  Assumes calls return just after a rising clock edge.
*/
module swb_host_model
(
  input  wire logic       clk,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  initial
  begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // Whole 8-bit characters only; data inverted once released
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(negedge clk);
    while (rx_ready !== 1'b1)
      @(negedge clk);
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask
  task automatic recv(input int lag, output logic [7:0] b);
    repeat (lag + 1) @(posedge clk);
    tx_ready <= 1'b1;
    @(negedge clk);
    while (tx_valid !== 1'b1)
      @(negedge clk);
    b = tx_data;
    @(posedge clk);
    tx_ready <= 1'b0;
  endtask
endmodule

/* tb/swb_cmd_unit_tb.sv */
/*
  Testbench for swb_cmd_unit with the host model and a pulled-up bus.
  Assumes the package, design, checker and model are compiled first.
*/
`define CHK(n, e, a) \
  begin \
    checks_done++; \
    if ((a) !== (e)) \
    begin \
      err_count++; \
      $display("[FAIL] %s exp %h got %h", n, e, a); \
    end \
  end
module swb_cmd_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import swb_pkg::*;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic              slave_low = 1'b0;
  logic              demand_low = 1'b0;
  logic              rx_valid, rx_ready, tx_valid, tx_ready, bus_i, hreadyout, hresp;
  logic              hwrite = 1'b0;
  logic [1:0]        htrans = 2'h0;
  logic [7:0]        rx_data, tx_data;
  logic [31:0]       haddr = 32'h0000_0000;
  logic [31:0]       hwdata = 32'h0000_0000;
  logic [31:0]       hrdata, d;
  swb_drv_t          drv;
  int                err_count = 0;
  int                checks_done = 0;
  int                cycles = 0;
  // Pull-up wire: low when the unit or a slave pulls it
  assign bus_i = !(drv.bus_oe || slave_low);
  always #4 clk = ~clk;
  swb_cmd_unit u_swb_cmd_unit (.clk(clk), .reset(reset), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .bus_i(bus_i), .demand_low(demand_low), .drv(drv), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  swb_host_model u_swb_host_model (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      test_done();
    end
  end
  task automatic rdy(output logic [31:0] v);
    @(negedge clk);
    while (hreadyout !== 1'b1)
      @(negedge clk);
    v = hrdata;
    @(posedge clk);
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    rdy(rd);
    htrans <= 2'h0;
    hwdata <= wd;
    rdy(rd);
  endtask
  task automatic t_regs();
    ahb(1'b0, 32'(OFS_SPU_LEN), d, d);
    `CHK("spu len", SPU_LEN_RST, d[23:0])
    ahb(1'b0, 32'(OFS_STATUS), d, d);
    `CHK("status", 9'h001, d[8:0])
    ahb(1'b0, 32'h0000_0200, d, d);
    `CHK("unmapped", 32'h0000_0000, d)
    ahb(1'b1, 32'(OFS_SPU_LEN), 32'h0000_0014, d);
    ahb(1'b1, 32'(OFS_PROG_LEN), 32'h0000_0000, d);
  endtask
  task automatic t_bit(input logic [7:0] c, input logic low);
    logic [7:0] b;
    logic       s;
    s = c[CMD_VAL] && !low;
    slave_low <= low;
    u_swb_host_model.send(c);
    u_swb_host_model.recv(3, b);
    `CHK("bit reply", {c[7:2], s, s}, b)
    if (c[CMD_OPT])
    begin
      u_swb_host_model.recv(0, b);
      `CHK("pullup reply", s ? RESP_SB_HI : RESP_SB_LO, b)
    end
    slave_low <= 1'b0;
  endtask
  task automatic t_pulse(input logic [7:0] c, input logic stop);
    logic [7:0] b;
    u_swb_host_model.send(c);
    repeat (4) @(negedge clk);
    `CHK("pulse kind", {c[CMD_VAL], !c[CMD_VAL]}, {drv.prog_en, drv.spu_en})
    if (stop)
      u_swb_host_model.send(CODE_PULSE_END);
    else
    begin
      // Load sensor ends the 5V pullup long before its 20-cycle length
      @(posedge clk);
      demand_low <= 1'b1;
      repeat (2) @(negedge clk);
      `CHK("load end", 1'b0, drv.spu_en)
    end
    u_swb_host_model.recv(2, b);
    demand_low <= 1'b0;
    `CHK("pulse reply", {c[7:2], 2'b00}, b)
    ahb(1'b0, 32'(OFS_STATUS), d, d);
    `CHK("armed", c[CMD_OPT], d[ST_ARMED])
  endtask
  task automatic t_accel(input logic [7:0] c);
    u_swb_host_model.send(c);
    ahb(1'b0, 32'(OFS_STATUS), d, d);
    `CHK("accel", {c[CMD_VAL], c[3:2]}, {d[ST_ACCEL], d[ST_SPD_LSB+:2]})
    `CHK("no reply", 1'b0, tx_valid)
    `CHK("mode", 3'(MODE_CMD), d[ST_MODE_LSB+:3])
  endtask
  task automatic t_data(input logic [7:0] v, e, input logic low, arm);
    logic [7:0] b;
    slave_low <= low;
    u_swb_host_model.send(CODE_DATA_MODE);
    u_swb_host_model.send(v);
    u_swb_host_model.recv(0, b);
    `CHK("data reply", e, b)
    if (arm)
    begin
      u_swb_host_model.recv(0, b);
      `CHK("armed reply", v[7] ? RESP_ARM_HI : RESP_ARM_LO, b)
    end
    // Leaves the unit in check mode; the next command byte is executed
    u_swb_host_model.send(CODE_CMD_MODE);
    slave_low <= 1'b0;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_bit(8'h89, 1'b0);
    t_bit(8'h99, 1'b1);
    t_bit(8'h9B, 1'b0);
    t_bit(8'h9B, 1'b1);
    // Limited length while armed
    t_pulse(8'hEF, 1'b0);
    t_data(8'hA5, 8'hA5, 1'b0, 1'b1);
    t_pulse(8'hED, 1'b0);
    // Programming pulse only once already disarmed
    t_pulse(8'hFD, 1'b1);
    // Disarmed before the accelerator goes on
    t_accel(8'hB9);
    // Bus held low: conflict at every position, host path taken
    t_data(8'h88, 8'hDD, 1'b1, 1'b0);
    t_accel(8'hA9);
    test_done();
  end
endmodule
